// [tlc_pkg.sv]
/*
  Shared constants and carrier types for the temperature limit compare block:
  register offsets, reset values, field positions, FSM states and timing counts.
  Assumes a 100 MHz mclk and a byte-wide register port that carries already-decoded transfers.
*/
package tlc_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'h05;
  localparam logic [7:0] ADDR_UPPER_LOW = 8'h06;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'h07;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'h08;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
  localparam logic [7:0] ADDR_OT_LIMIT = 8'h20;
  localparam logic [7:0] ADDR_OT_HYST = 8'h21;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h22;

  // Reset values
  localparam logic [7:0] RST_RATE = 8'h04;
  localparam logic [7:0] RST_UPPER_HIGH = 8'h55;
  localparam logic [1:0] RST_UPPER_FRAC = 2'h0;
  localparam logic [7:0] RST_LOWER_HIGH = 8'h00;
  localparam logic [1:0] RST_LOWER_FRAC = 2'h0;
  localparam logic [7:0] RST_OT_LIMIT = 8'h55;
  localparam logic [7:0] RST_OT_HYST = 8'h0A;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [2:0] RST_CONFIG = 3'h0;

  // Field positions
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_MODE2_BIT = 5;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_HIGH_BIT = 6;
  localparam int STAT_LOW_BIT = 5;
  localparam int STAT_OT_BIT = 0;
  localparam int TIMEOUT_EN_BIT = 7;
  localparam logic [3:0] RATE_MAX_CODE = 4'h9;
  localparam logic [3:0] RATE_TOP_SHIFT = 4'h9;
  localparam logic [9:0] RATE_RESERVED_TICKS = 10'h020;

  // Timing: base tick is 1/32 s, the fastest conversion period
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 31_250_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BUS_TIMEOUT_MS = 25;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int CNT_W = 22;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : tlc_pkg

// [conv_wait_timer.sv]
/*
  Wait timer between conversions: divides mclk into 1/32 s ticks and counts
  2^(9-code) ticks after each start pulse, or 32 ticks for codes above 9.
  Assumes start and cancel are single-cycle pulses from the conversion FSM.
*/
`timescale 1ns/1ps
module conv_wait_timer #(
  parameter logic [21:0] TICK_CYCLES = 22'(tlc_pkg::TICK_CYCLES)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic cancel,
  input wire logic [3:0] rate_code,
  output logic done
);

  logic [21:0] div_q, div_d;
  logic [9:0] ticks_q, ticks_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // Reserved codes fall back to the default rate rather than stalling
  function automatic logic [9:0] wait_ticks(input logic [3:0] code);
    if (code > tlc_pkg::RATE_MAX_CODE)
      wait_ticks = tlc_pkg::RATE_RESERVED_TICKS;
    else
      wait_ticks = 10'h001 << (tlc_pkg::RATE_TOP_SHIFT - code);
  endfunction : wait_ticks

  always_comb
  begin
    div_d = div_q;
    ticks_d = ticks_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (cancel)
    begin
      busy_d = 1'b0;
    end
    else if (start)
    begin
      busy_d = 1'b1;
      div_d = '0;
      ticks_d = wait_ticks(rate_code);
    end
    else if (busy_q)
    begin
      if (div_q == TICK_CYCLES - 22'h1)
      begin
        div_d = '0;
        if (ticks_q == 10'h001)
        begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
        else
          ticks_d = ticks_q - 10'h001;
      end
      else
        div_d = div_q + 22'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div_q <= '0;
      ticks_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      ticks_q <= ticks_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

  done_needs_busy_a: assert property (@(posedge mclk) disable iff (reset)
    done_q |-> $past(busy_q))
    else $error("Wait done without a running wait");

endmodule : conv_wait_timer

// [bus_idle_timer.sv]
/*
  Bus inactivity timer: counts idle cycles inside a transaction and pulses
  abort when the limit is reached while enabled.
  Assumes activity is a pulse per bus edge from the serial front end.
*/
`timescale 1ns/1ps
module bus_idle_timer #(
  parameter logic [21:0] TIMEOUT_CYCLES = 22'(tlc_pkg::BUS_TIMEOUT_CYCLES)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic in_transaction,
  input wire logic activity,
  output logic abort
);

  logic [21:0] cnt_q, cnt_d;
  logic abort_q, abort_d;

  always_comb
  begin
    cnt_d = cnt_q;
    abort_d = 1'b0;
    if (!enable || !in_transaction || activity)
      cnt_d = '0;
    else if (cnt_q == TIMEOUT_CYCLES - 22'h1)
    begin
      cnt_d = '0;
      abort_d = 1'b1;
    end
    else
      cnt_d = cnt_q + 22'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      abort_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      abort_q <= abort_d;
    end
  end

  assign abort = abort_q;

  abort_when_enabled_a: assert property (@(posedge mclk) disable iff (reset)
    abort_q |-> $past(enable) && $past(in_transaction))
    else $error("Bus abort while timeout disabled or idle");

endmodule : bus_idle_timer

// [temp_limit_compare_ctrl.sv]
/*
  Conversion scheduling and limit comparison for a small temperature sensor:
  byte register file, conversion FSM, window and over-temperature comparators,
  status flags and the two open-drain outputs.
  Assumes an external converter (conv_start / conv_done / conv_result) and a
  serial front end that delivers decoded byte reads and writes on reg_req.
  // Overview of operation
  // - Low four rate bits select inter-conversion wait
  // - Codes 0-9 give 1/16 to 32 per second
  // - Upper limit ten bits, low byte top two
  // - Lower limit ten bits, same layout
  // - Violation when result <= lower or > upper
  // - Violation sets status flag, drives alert output
  // - Overtemp output asserts when result exceeds limit
  // - Second-thermostat mode asserts alert above upper limit
  // - Hysteresis resets to ten, writable any time
  // - Second-thermostat release uses the same hysteresis
  // - One-shot write in standby runs one conversion
  // - One-shot write ignored in continuous mode
  // - Timeout bit 7 enables bus timeout
  // - Enabled timeout aborts after 25 ms idle
  // - Overtemp holds until below limit minus hysteresis
  // - Standby bit selects continuous or standby
*/
`timescale 1ns/1ps
module temp_limit_compare_ctrl #(
  parameter logic [21:0] TICK_CYCLES = 22'(tlc_pkg::TICK_CYCLES),
  parameter logic [21:0] TIMEOUT_CYCLES = 22'(tlc_pkg::BUS_TIMEOUT_CYCLES)
) (
  input wire logic mclk,
  input wire logic reset,
  input tlc_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic analog_standby,
  input wire logic bus_in_transaction,
  input wire logic bus_activity,
  output logic bus_timeout_abort,
  input wire logic alert_response,
  output logic overtemp_output_o,
  output logic overtemp_output_oe_n,
  output logic alert_or_second_overtemp_pin_o,
  output logic alert_or_second_overtemp_pin_oe_n
);

  // Register file
  logic [7:0] rate_q, rate_d;
  logic [7:0] upper_high_q, upper_high_d;
  logic [1:0] upper_frac_q, upper_frac_d;
  logic [7:0] lower_high_q, lower_high_d;
  logic [1:0] lower_frac_q, lower_frac_d;
  logic [7:0] ot_limit_q, ot_limit_d;
  logic [7:0] ot_hyst_q, ot_hyst_d;
  logic [7:0] timeout_q, timeout_d;
  logic mask_q, mask_d;
  logic standby_q, standby_d;
  logic mode2_q, mode2_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] frac_lock_q, frac_lock_d;
  logic limit_wr_q, limit_wr_d;

  // Conversion FSM
  tlc_pkg::conv_state_e state_q, state_d;
  logic conv_start_q, conv_start_d;
  logic [9:0] result_q, result_d;
  logic eval_q, eval_d;
  logic wait_start;
  logic wait_cancel;
  logic wait_done;

  // Comparison and outputs
  logic flag_high_q, flag_high_d;
  logic flag_low_q, flag_low_d;
  logic flag_ot_q, flag_ot_d;
  logic ot_q, ot_d;
  logic second_q, second_d;
  logic alert_q, alert_d;

  logic wr_hit, rd_hit;
  logic oneshot_wr;
  logic status_rd;
  logic [9:0] upper10, lower10, ot10, hyst10;
  logic [10:0] ot_release, upper_release;
  logic above_upper, at_or_below_lower, above_ot;
  logic below_ot_release, below_upper_release;

  assign wr_hit = reg_req.wr;
  assign rd_hit = reg_req.rd;
  assign oneshot_wr = wr_hit && (reg_req.addr == tlc_pkg::ADDR_ONE_SHOT);
  assign status_rd = rd_hit && (reg_req.addr == tlc_pkg::ADDR_STATUS);

  // Limits widened to the 10-bit result scale
  assign upper10 = {upper_high_q, upper_frac_q};
  assign lower10 = {lower_high_q, lower_frac_q};
  assign ot10 = {ot_limit_q, 2'b00};
  assign hyst10 = {ot_hyst_q, 2'b00};
  // A borrow means the release point is below zero, so the output never releases
  assign ot_release = {1'b0, ot10} - {1'b0, hyst10};
  assign upper_release = {1'b0, upper10} - {1'b0, hyst10};
  assign above_upper = result_q > upper10;
  assign at_or_below_lower = result_q <= lower10;
  assign above_ot = result_q > ot10;
  assign below_ot_release = !ot_release[10] && ({1'b0, result_q} < ot_release);
  assign below_upper_release = !upper_release[10] && ({1'b0, result_q} < upper_release);

  always_comb
  begin
    rate_d = rate_q;
    upper_high_d = upper_high_q;
    upper_frac_d = upper_frac_q;
    lower_high_d = lower_high_q;
    lower_frac_d = lower_frac_q;
    ot_limit_d = ot_limit_q;
    ot_hyst_d = ot_hyst_q;
    timeout_d = timeout_q;
    mask_d = mask_q;
    standby_d = standby_q;
    mode2_d = mode2_q;
    frac_lock_d = frac_lock_q;
    limit_wr_d = 1'b0;
    rvalid_d = rd_hit;
    rdata_d = rdata_q;
    if (wr_hit)
    begin
      case (reg_req.addr)
        tlc_pkg::ADDR_CONFIG:
        begin
          mask_d = reg_req.wdata[tlc_pkg::CFG_MASK_BIT];
          standby_d = reg_req.wdata[tlc_pkg::CFG_STANDBY_BIT];
          mode2_d = reg_req.wdata[tlc_pkg::CFG_MODE2_BIT];
        end
        tlc_pkg::ADDR_RATE: rate_d = reg_req.wdata;
        tlc_pkg::ADDR_UPPER_HIGH: upper_high_d = reg_req.wdata;
        tlc_pkg::ADDR_UPPER_LOW: upper_frac_d = reg_req.wdata[7:6];
        tlc_pkg::ADDR_LOWER_HIGH: lower_high_d = reg_req.wdata;
        tlc_pkg::ADDR_LOWER_LOW: lower_frac_d = reg_req.wdata[7:6];
        tlc_pkg::ADDR_OT_LIMIT: ot_limit_d = reg_req.wdata;
        tlc_pkg::ADDR_OT_HYST: ot_hyst_d = reg_req.wdata;
        tlc_pkg::ADDR_TIMEOUT: timeout_d = reg_req.wdata;
        default: ;
      endcase
      // Limit changes are judged against the stored result right away
      case (reg_req.addr)
        tlc_pkg::ADDR_UPPER_HIGH, tlc_pkg::ADDR_UPPER_LOW, tlc_pkg::ADDR_LOWER_HIGH,
        tlc_pkg::ADDR_LOWER_LOW, tlc_pkg::ADDR_OT_LIMIT, tlc_pkg::ADDR_OT_HYST:
          limit_wr_d = 1'b1;
        default: ;
      endcase
    end
    if (rd_hit)
    begin
      case (reg_req.addr)
        tlc_pkg::ADDR_TEMP_HIGH:
        begin
          rdata_d = result_q[9:2];
          // Freeze the fraction so a later low-byte read matches this high byte
          frac_lock_d = result_q[1:0];
        end
        tlc_pkg::ADDR_STATUS:
          rdata_d = {(state_q == tlc_pkg::ST_CONV), flag_high_q, flag_low_q, 4'h0, flag_ot_q};
        tlc_pkg::ADDR_TEMP_LOW: rdata_d = {frac_lock_q, 6'h00};
        tlc_pkg::ADDR_CONFIG: rdata_d = {mask_q, standby_q, mode2_q, 5'h00};
        tlc_pkg::ADDR_RATE: rdata_d = rate_q;
        tlc_pkg::ADDR_UPPER_HIGH: rdata_d = upper_high_q;
        tlc_pkg::ADDR_UPPER_LOW: rdata_d = {upper_frac_q, 6'h00};
        tlc_pkg::ADDR_LOWER_HIGH: rdata_d = lower_high_q;
        tlc_pkg::ADDR_LOWER_LOW: rdata_d = {lower_frac_q, 6'h00};
        tlc_pkg::ADDR_OT_LIMIT: rdata_d = ot_limit_q;
        tlc_pkg::ADDR_OT_HYST: rdata_d = ot_hyst_q;
        tlc_pkg::ADDR_TIMEOUT: rdata_d = timeout_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rate_q <= tlc_pkg::RST_RATE;
      upper_high_q <= tlc_pkg::RST_UPPER_HIGH;
      upper_frac_q <= tlc_pkg::RST_UPPER_FRAC;
      lower_high_q <= tlc_pkg::RST_LOWER_HIGH;
      lower_frac_q <= tlc_pkg::RST_LOWER_FRAC;
      ot_limit_q <= tlc_pkg::RST_OT_LIMIT;
      ot_hyst_q <= tlc_pkg::RST_OT_HYST;
      timeout_q <= tlc_pkg::RST_TIMEOUT;
      {mask_q, standby_q, mode2_q} <= tlc_pkg::RST_CONFIG;
      frac_lock_q <= 2'h0;
      limit_wr_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rate_q <= rate_d;
      upper_high_q <= upper_high_d;
      upper_frac_q <= upper_frac_d;
      lower_high_q <= lower_high_d;
      lower_frac_q <= lower_frac_d;
      ot_limit_q <= ot_limit_d;
      ot_hyst_q <= ot_hyst_d;
      timeout_q <= timeout_d;
      mask_q <= mask_d;
      standby_q <= standby_d;
      mode2_q <= mode2_d;
      frac_lock_q <= frac_lock_d;
      limit_wr_q <= limit_wr_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Conversion scheduling
  assign wait_start = (state_q == tlc_pkg::ST_CONV) && conv_done && !standby_q;
  assign wait_cancel = (state_q == tlc_pkg::ST_WAIT) && standby_q;

  always_comb
  begin
    state_d = state_q;
    conv_start_d = 1'b0;
    result_d = result_q;
    eval_d = limit_wr_q;
    case (state_q)
      tlc_pkg::ST_IDLE:
      begin
        if (!standby_q || oneshot_wr)
        begin
          state_d = tlc_pkg::ST_CONV;
          conv_start_d = 1'b1;
        end
      end
      tlc_pkg::ST_CONV:
      begin
        if (conv_done)
        begin
          result_d = conv_result;
          eval_d = 1'b1;
          state_d = standby_q ? tlc_pkg::ST_IDLE : tlc_pkg::ST_WAIT;
        end
      end
      tlc_pkg::ST_WAIT:
      begin
        // One-shot writes are not looked at here, so they fall away in run mode
        if (standby_q)
          state_d = tlc_pkg::ST_IDLE;
        else if (wait_done)
        begin
          state_d = tlc_pkg::ST_CONV;
          conv_start_d = 1'b1;
        end
      end
      default: state_d = tlc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= tlc_pkg::ST_IDLE;
      conv_start_q <= 1'b0;
      result_q <= 10'h000;
      eval_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      conv_start_q <= conv_start_d;
      result_q <= result_d;
      eval_q <= eval_d;
    end
  end

  conv_wait_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wait (
    .mclk(mclk),
    .reset(reset),
    .start(wait_start),
    .cancel(wait_cancel),
    .rate_code(rate_q[3:0]),
    .done(wait_done)
  );

  bus_idle_timer #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_idle (
    .mclk(mclk),
    .reset(reset),
    .enable(timeout_q[tlc_pkg::TIMEOUT_EN_BIT]),
    .in_transaction(bus_in_transaction),
    .activity(bus_activity),
    .abort(bus_timeout_abort)
  );

  // Comparison, status flags and pin states; a new violation beats a clearing read
  always_comb
  begin
    flag_high_d = flag_high_q;
    flag_low_d = flag_low_q;
    flag_ot_d = flag_ot_q;
    ot_d = ot_q;
    second_d = second_q;
    alert_d = alert_q;
    if (status_rd)
    begin
      flag_high_d = flag_high_q && above_upper;
      flag_low_d = flag_low_q && at_or_below_lower;
      flag_ot_d = flag_ot_q && above_ot;
    end
    if (alert_response && !flag_high_q && !flag_low_q)
      alert_d = 1'b0;
    if (eval_q)
    begin
      if (above_upper)
        flag_high_d = 1'b1;
      if (at_or_below_lower)
        flag_low_d = 1'b1;
      if (above_ot)
      begin
        flag_ot_d = 1'b1;
        ot_d = 1'b1;
      end
      else if (below_ot_release)
        ot_d = 1'b0;
      if (above_upper)
        second_d = 1'b1;
      else if (below_upper_release)
        second_d = 1'b0;
      if ((above_upper || at_or_below_lower) && !mask_q)
        alert_d = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      flag_high_q <= 1'b0;
      flag_low_q <= 1'b0;
      flag_ot_q <= 1'b0;
      ot_q <= 1'b0;
      second_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      flag_high_q <= flag_high_d;
      flag_low_q <= flag_low_d;
      flag_ot_q <= flag_ot_d;
      ot_q <= ot_d;
      second_q <= second_d;
      alert_q <= alert_d;
    end
  end

  // Open-drain: pins only ever pull low, enable is active low
  assign overtemp_output_o = 1'b0;
  assign overtemp_output_oe_n = !ot_q;
  assign alert_or_second_overtemp_pin_o = 1'b0;
  assign alert_or_second_overtemp_pin_oe_n = mode2_q ? !second_q : !alert_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign conv_start = conv_start_q;
  assign analog_standby = standby_q && (state_q == tlc_pkg::ST_IDLE);

  upper_flag_set_a: assert property (@(posedge mclk) disable iff (reset)
    eval_q && (result_q > upper10) |=> flag_high_q)
    else $error("High flag not set on upper violation");

  lower_flag_set_a: assert property (@(posedge mclk) disable iff (reset)
    eval_q && (result_q <= lower10) |=> flag_low_q)
    else $error("Low flag not set at or below lower limit");

  overtemp_assert_a: assert property (@(posedge mclk) disable iff (reset)
    eval_q && (result_q > ot10) |=> !overtemp_output_oe_n)
    else $error("Overtemp pin not driven above limit");

  overtemp_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ot_q && !(eval_q && below_ot_release) |=> ot_q)
    else $error("Overtemp released above hysteresis point");

  second_mode_a: assert property (@(posedge mclk) disable iff (reset)
    mode2_q && eval_q && above_upper && !(wr_hit && reg_req.addr == tlc_pkg::ADDR_CONFIG)
      |=> !alert_or_second_overtemp_pin_oe_n)
    else $error("Second thermostat pin not driven above upper limit");

  low_byte_zero_a: assert property (@(posedge mclk) disable iff (reset)
    rd_hit && (reg_req.addr == tlc_pkg::ADDR_UPPER_LOW) |=> reg_rvalid && (reg_rdata[5:0] == 6'h00))
    else $error("Upper limit low byte spare bits not zero");

  hyst_reset_a: assert property (@(posedge mclk)
    reset |=> ot_hyst_q == 8'h0A)
    else $error("Hysteresis not ten after reset");

  one_shot_start_a: assert property (@(posedge mclk) disable iff (reset)
    (state_q == tlc_pkg::ST_IDLE) && standby_q && oneshot_wr |=> conv_start_q ##1 state_q == tlc_pkg::ST_CONV)
    else $error("One-shot in standby did not start a conversion");

  one_shot_ignored_a: assert property (@(posedge mclk) disable iff (reset)
    (state_q == tlc_pkg::ST_WAIT) && !standby_q && oneshot_wr && !wait_done |=> !conv_start_q)
    else $error("One-shot accepted in continuous mode");

  standby_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    (state_q == tlc_pkg::ST_IDLE) && standby_q && !oneshot_wr |=> !conv_start_q)
    else $error("Conversion started in standby without one-shot");

endmodule : temp_limit_compare_ctrl

// [conv_model.sv]
/*
  Converter stand-in: answers each start with one done pulse a few cycles later.
  Assumes the bench sets the temperature and the extra lag.
*/
`timescale 1ns/1ps
module conv_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic [9:0] temp,
  input wire logic [2:0] lag,
  output logic conv_done,
  output logic [9:0] conv_result
);
  logic [3:0] cnt_q;
  logic [9:0] last_q;
  // Result valid only with done, else a changing pattern
  assign conv_result = conv_done ? last_q : ~last_q;
  always_ff @(posedge mclk)
  begin
    conv_done <= 1'b0;
    if (reset)
    begin
      cnt_q <= 4'h0;
      last_q <= 10'h000;
    end
    else if (conv_start)
      cnt_q <= {1'b0, lag} + 4'h1;
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      conv_done <= (cnt_q == 4'h1);
      last_q <= (cnt_q == 4'h1) ? temp : ~last_q;
    end
  end
endmodule : conv_model

// [temp_limit_compare_ctrl_tb.sv]
/*
  Self-checking bench: register defaults, thermostat hysteresis, window flags,
  conversion pacing, one-shot in standby and bus timeout.
  Assumes shortened tick and timeout counts set through parameters.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module temp_limit_compare_ctrl_tb;
  localparam int TK = 10;
  localparam int TO = 20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  tlc_pkg::reg_req_s req = '0;
  logic [7:0] rdata, d;
  logic rvalid, cstart, cdone, stby, abort, ot_o, ot_n, al_o, al_n, ot_x;
  logic in_tr = 1'b0, act = 1'b0, ara = 1'b0;
  logic [9:0] cres, temp = 10'h000;
  logic [2:0] lag = 3'h1;
  int num_errors = 0, checks = 0, n, i, t;
  logic [7:0] ra [8] = '{8'h04, 8'h05, 8'h06, 8'h20, 8'h21, 8'h22, 8'h0f, 8'h30};
  logic [7:0] rv [8] = '{8'h04, 8'h55, 8'h00, 8'h55, 8'h0a, 8'h00, 8'h00, 8'h00};
  int cv [6] = '{341, 300, 299, 340, 301, 1023};
  temp_limit_compare_ctrl #(.TICK_CYCLES(22'(TK)), .TIMEOUT_CYCLES(22'(TO))) dut (.mclk(mclk), .reset(reset),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .conv_start(cstart), .conv_done(cdone),
    .conv_result(cres), .analog_standby(stby), .bus_in_transaction(in_tr), .bus_activity(act),
    .bus_timeout_abort(abort), .alert_response(ara), .overtemp_output_o(ot_o), .overtemp_output_oe_n(ot_n),
    .alert_or_second_overtemp_pin_o(al_o), .alert_or_second_overtemp_pin_oe_n(al_n));
  conv_model adc (.mclk(mclk), .reset(reset), .conv_start(cstart), .temp(temp), .lag(lag), .conv_done(cdone),
    .conv_result(cres));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge mclk);
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    req = '0;
    `CHK("rvalid", 1'b1, rvalid)
    v = rdata;
  endtask : rd
  task automatic wait_for(ref logic s, input int lim, output int c);
    c = 0;
    do
    begin
      @(negedge mclk);
      c++;
    end
    while (s !== 1'b1 && c < lim);
  endtask : wait_for
  task automatic put(input int v);
    temp = 10'(v);
    lag = 3'($urandom_range(0, 5));
    wait_for(cdone, 400, n);
    repeat (3) @(negedge mclk);
  endtask : put
  function automatic logic hys(input logic prev, input int r, input int hi, input int lo);
    return r > hi ? 1'b1 : (r < lo ? 1'b0 : prev);
  endfunction : hys
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    close_out();
  end
  initial
  begin
    n = $urandom(32'h64c2);
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    foreach (ra[k])
    begin
      rd(ra[k], d);
      `CHK("default", rv[k], d)
    end
    for (i = 6; i <= 8; i += 2)
    begin
      t = $urandom;
      wr(8'(i), 8'(t));
      rd(8'(i), d);
      `CHK("limit low byte", 8'(t) & 8'hc0, d)
      wr(8'(i), 8'h00);
    end
    t = $urandom;
    wr(8'h21, 8'(t));
    rd(8'h21, d);
    `CHK("hysteresis", 8'(t), d)
    wr(8'h21, 8'h0a);
    $display("test registers done");
    for (i = 9; i >= 7; i--)
    begin
      wr(8'h04, 8'(i));
      repeat (3) wait_for(cstart, 2000, n);
      `CHK("gap", 1'b1, n >= (TK << (9 - i)) && n <= (TK << (9 - i)) + 14)
    end
    // Reserved code falls back to the default rate
    wr(8'h04, 8'h0a);
    repeat (2) wait_for(cstart, 2000, n);
    `CHK("reserved rate", 1'b1, n >= (TK * 32) && n <= (TK * 32) + 14)
    wr(8'h04, 8'h07);
    $display("test rate done");
    wr(8'h03, 8'h20);
    ot_x = 1'b0;
    for (i = 0; i < 14; i++)
    begin
      t = (i < 6) ? cv[i] : $urandom_range(250, 400);
      put(t);
      ot_x = hys(ot_x, t, 340, 300);
      `CHK("overtemp pin", !ot_x, ot_n)
      `CHK("second pin", !ot_x, al_n)
    end
    // Mid-wait in run mode: a one-shot must not start anything
    wr(8'h0f, 8'($urandom));
    `CHK("one shot run", 1'b0, cstart)
    $display("test thermostat done");
    wr(8'h03, 8'h00);
    put(0);
    // First read flushes flags left over from the thermostat run
    rd(8'h01, d);
    rd(8'h01, d);
    `CHK("low flag", 8'h20, d & 8'h60)
    `CHK("alert pin", 1'b0, al_n)
    put(341);
    rd(8'h01, d);
    `CHK("flags", 8'h61, d & 8'h61)
    put(100);
    rd(8'h01, d);
    rd(8'h01, d);
    `CHK("flags clear", 8'h00, d & 8'h61)
    ara = 1'b1;
    @(negedge mclk);
    ara = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("alert release", 1'b1, al_n)
    `CHK("drive level", 2'b00, {ot_o, al_o})
    wr(8'h03, 8'h80);
    put(0);
    `CHK("masked alert", 1'b1, al_n)
    $display("test window done");
    wr(8'h03, 8'h40);
    repeat (100) @(negedge mclk);
    `CHK("standby", 1'b1, stby)
    wait_for(cstart, 100, n);
    `CHK("idle", 1'b0, cstart)
    wr(8'h0f, 8'($urandom));
    `CHK("one shot", 1'b1, cstart)
    put(341);
    `CHK("one shot compare", 1'b0, ot_n)
    wait_for(cstart, 100, n);
    `CHK("back to idle", 1'b0, cstart)
    $display("test one shot done");
    in_tr = 1'b1;
    wait_for(abort, 60, n);
    `CHK("timeout off", 1'b0, abort)
    wr(8'h22, 8'h80);
    act = 1'b1;
    @(negedge mclk);
    act = 1'b0;
    wait_for(abort, 60, n);
    `CHK("timeout", 1'b1, n >= TO - 1 && n <= TO + 3)
    in_tr = 1'b0;
    $display("test timeout done");
    close_out();
  end
endmodule : temp_limit_compare_ctrl_tb
